// ===== hw/flash_port_device.sv
// Overview of operation
// R01 - Address high on port 2, low on port 1
// R02 - Programmer selects operation by configuration pins
// R03 - Reset high, latch low, store strobe high
// R04 - Read with all lines low, normal supply
// R05 - Read returns code bytes or option bits
// R06 - Lock programmed: reads return no valid data
// R07 - Program at 12V, select low, drive high
// R08 - Verify at 12V, select high, drive low
// R09 - Programmer verifies each byte after programming
// R10 - Internal 4K byte writable readable store
// R11 - Lock zero refuses all flash access; the code still allows option bit reads and writes and table reads
// R12 - Restricted: external table read denied internal
// R13 - Internal table reads always see everything
// R14 - Unrestricted option: table reads unrestricted
// R15 - Other pin combinations: no write, undriven
module flash_port_device #(
  parameter int BYTES = flash_port_pkg::FLASH_BYTES
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CLOCK_EN_I,
  flash_port_if.device port,
  input wire logic TABLE_READ_I,
  input wire logic TABLE_FROM_EXTERNAL_I,
  input wire logic [15:0] TABLE_ADDR_I,
  output logic TABLE_INTERNAL_OK_O,
  output logic [7:0] TABLE_DATA_O,
  output logic LOCKED_O,
  output logic RESTRICTED_O
);
  // Array storage; bytes not written since reset read as erased
  logic [7:0] mem [BYTES];
  logic [BYTES-1:0] written;
  logic [1:0] option_bits;
  // First synchroniser stage, read only by the second stage
  logic [7:0] addr_high_meta;
  logic [7:0] addr_low_meta;
  logic [7:0] data_meta;
  logic [3:0] ctrl_meta;
  logic chip_sel_meta;
  logic read_drive_meta;
  logic prog_lvl_meta;
  logic supply_meta;
  logic reset_pin_meta;
  logic latch_meta;
  logic store_meta;
  // Second synchroniser stage, the only pin view the logic reads
  logic [15:0] addr;
  logic [7:0] data_in;
  logic [3:0] ctrl;
  logic ce_n;
  logic oe_n;
  logic prog_lvl;
  logic vih;
  logic rst_p;
  logic ale_n;
  logic store_n;
  // R01 address and data pins
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      addr_high_meta <= '0;
      addr_low_meta <= '0;
      data_meta <= '0;
      addr <= '0;
      data_in <= '0;
    end else if (CLOCK_EN_I) begin
      addr_high_meta <= port.addr_high;
      addr_low_meta <= port.addr_low;
      data_meta <= port.data_bus;
      addr <= {addr_high_meta, addr_low_meta};
      data_in <= data_meta;
    end
  end
  // R02 configuration pins
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ctrl_meta <= '0;
      chip_sel_meta <= 1'b1;
      read_drive_meta <= 1'b1;
      prog_lvl_meta <= 1'b0;
      supply_meta <= 1'b0;
      reset_pin_meta <= 1'b0;
      latch_meta <= 1'b1;
      store_meta <= 1'b0;
      ctrl <= '0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      prog_lvl <= 1'b0;
      vih <= 1'b0;
      rst_p <= 1'b0;
      ale_n <= 1'b1;
      store_n <= 1'b0;
    end else if (CLOCK_EN_I) begin
      ctrl_meta <= port.flash_ctrl_line;
      chip_sel_meta <= port.chip_sel_n;
      read_drive_meta <= port.read_drive_n;
      prog_lvl_meta <= port.programming_level;
      supply_meta <= port.supply_high;
      reset_pin_meta <= port.reset_pin;
      latch_meta <= port.addr_latch_n;
      store_meta <= port.program_store_strobe_n;
      ctrl <= ctrl_meta;
      ce_n <= chip_sel_meta;
      oe_n <= read_drive_meta;
      prog_lvl <= prog_lvl_meta;
      vih <= supply_meta;
      rst_p <= reset_pin_meta;
      ale_n <= latch_meta;
      store_n <= store_meta;
    end
  end
  // R03 flash mode strap condition
  logic mode_ok;
  assign mode_ok = rst_p && !ale_n && store_n && (ctrl == 4'h0);
  // R04 read select
  logic op_read;
  assign op_read = mode_ok && !ce_n && !oe_n && vih && !prog_lvl;
  // R07 program select
  logic op_prog;
  assign op_prog = mode_ok && !ce_n && oe_n && prog_lvl;
  // R08 verify select
  logic op_verify;
  assign op_verify = mode_ok && ce_n && !oe_n && prog_lvl;
  // R05 option address decode
  logic is_option;
  assign is_option = (addr == flash_port_pkg::OPTION_ADDR);
  // Array index and lock state
  logic [flash_port_pkg::ARRAY_AW-1:0] idx;
  logic unlocked;
  assign idx = addr[flash_port_pkg::ARRAY_AW-1:0];
  assign unlocked = option_bits[flash_port_pkg::LOCK_BIT_POS];
  // Byte as stored, erased until first written
  logic [7:0] stored;
  assign stored = written[idx] ? mem[idx] : flash_port_pkg::ERASED_BYTE;
  // Program strobe must be held steady before the write is taken
  logic [7:0] hold_cnt;
  logic [15:0] hold_addr;
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hold_cnt <= '0;
      hold_addr <= '0;
    end else if (CLOCK_EN_I) begin
      hold_addr <= addr;
      if (!op_prog || addr != hold_addr)
        hold_cnt <= '0;
      else if (hold_cnt != 8'(flash_port_pkg::PROG_CYCLES))
        hold_cnt <= hold_cnt + 8'h01;
    end
  end
  // R07 one write per hold
  logic write_now;
  logic array_write;
  assign write_now = op_prog &&
    (hold_cnt == 8'(flash_port_pkg::PROG_CYCLES - 1));
  // R11 no array write while locked
  assign array_write = write_now && !is_option && unlocked;
  // R10 array write clears bits
  always_ff @(posedge CLOCK_I) begin
    if (CLOCK_EN_I && array_write)
      mem[idx] <= stored & data_in;
  end
  // R10 bytes programmed since reset
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I)
      written <= '0;
    else if (CLOCK_EN_I && array_write)
      written[idx] <= 1'b1;
  end
  // R07 option bits towards zero
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I)
      option_bits <= flash_port_pkg::OPTION_RESET;
    else if (CLOCK_EN_I && write_now && is_option)
      option_bits <= option_bits & data_in[1:0];
  end
  // R05 code or option bits
  // R06 locked array reads filler
  logic [7:0] next_data;
  always_comb begin
    if (is_option)
      next_data = {6'h00, option_bits};
    else if (!unlocked)
      next_data = flash_port_pkg::LOCKED_READ;
    else
      next_data = stored;
  end
  // R15 drive only on read or verify
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      port.data_dev_out <= '0;
      port.data_dev_oe_n <= 1'b1;
    end else if (CLOCK_EN_I) begin
      port.data_dev_out <= next_data;
      port.data_dev_oe_n <= !(op_read || op_verify);
    end
  end
  // R12 external reads need permission
  logic tbl_internal;
  logic tbl_ok;
  logic [flash_port_pkg::ARRAY_AW-1:0] tbl_idx;
  logic [7:0] tbl_byte;
  assign tbl_internal = (TABLE_ADDR_I < 16'(BYTES));
  assign tbl_ok = !TABLE_FROM_EXTERNAL_I ||
    option_bits[flash_port_pkg::RESTRICT_BIT_POS];
  assign tbl_idx = TABLE_ADDR_I[flash_port_pkg::ARRAY_AW-1:0];
  assign tbl_byte = written[tbl_idx] ? mem[tbl_idx] :
    flash_port_pkg::ERASED_BYTE;
  // R13 internal reads allowed
  // R14 unrestricted reads allowed
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TABLE_INTERNAL_OK_O <= 1'b0;
      TABLE_DATA_O <= '0;
    end else if (CLOCK_EN_I && TABLE_READ_I) begin
      TABLE_INTERNAL_OK_O <= tbl_internal && tbl_ok;
      TABLE_DATA_O <= (tbl_internal && tbl_ok) ?
        tbl_byte : 8'h00;
    end
  end
  // Option state for the core
  assign LOCKED_O = !unlocked;
  assign RESTRICTED_O = !option_bits[flash_port_pkg::RESTRICT_BIT_POS];
endmodule

// ===== hw/flash_port_pkg.sv
package flash_port_pkg;
  // Flash array size and address widths
  localparam int FLASH_BYTES = 4096;
  localparam int ARRAY_AW = 12;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Option bit locations in the upper address space
  localparam logic [15:0] OPTION_ADDR = 16'hFFFF;
  localparam int LOCK_BIT_POS = 0;
  localparam int RESTRICT_BIT_POS = 1;
  // Reset values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] OPTION_RESET = 2'h3;
  localparam logic [7:0] LOCKED_READ = 8'hFF;
  // Cycles a program strobe must hold before the write is taken
  localparam int PROG_TIME_NS = 200;
  localparam int CLOCK_NS = 40;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
  // Host sequencing counts
  localparam int SETTLE_CYCLES = 3;
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_VERIFY} op_e;
endpackage

// ===== hw/flash_port_if.sv
interface flash_port_if;
  logic [7:0] addr_high;
  logic [7:0] addr_low;
  logic [7:0] data_host_out;
  logic data_host_oe_n;
  logic [7:0] data_dev_out;
  logic data_dev_oe_n;
  logic [3:0] flash_ctrl_line;
  logic chip_sel_n;
  logic read_drive_n;
  logic programming_level;
  logic supply_high;
  logic reset_pin;
  logic addr_latch_n;
  logic program_store_strobe_n;
  logic [7:0] data_bus;
  // Resolved data bus level from the two enables
  assign data_bus = !data_dev_oe_n ? data_dev_out :
                    !data_host_oe_n ? data_host_out : 8'hFF;
  modport device (input addr_high, addr_low, flash_ctrl_line, chip_sel_n,
    read_drive_n, programming_level, supply_high, reset_pin, addr_latch_n,
    program_store_strobe_n, data_bus, output data_dev_out, data_dev_oe_n);
  modport host (output addr_high, addr_low, flash_ctrl_line, chip_sel_n,
    read_drive_n, programming_level, supply_high, reset_pin, addr_latch_n,
    program_store_strobe_n, data_host_out, data_host_oe_n, input data_bus);
endinterface

// ===== hw/flash_port_host.sv
module flash_port_host (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CLOCK_EN_I,
  flash_port_if.host port,
  input wire logic REQ_I,
  input wire flash_port_pkg::op_e OP_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  output logic BUSY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O,
  output logic MISMATCH_O
);
  typedef enum logic [2:0] {IDLE, SETUP, PROG, VERIFY, SAMPLE} state_e;
  state_e state;
  logic [7:0] cnt;
  logic [7:0] wdata;
  logic [7:0] bus_meta, bus_sync;
  // Synchronise the shared data bus
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      bus_meta <= '0;
      bus_sync <= '0;
    end else if (CLOCK_EN_I) begin
      bus_meta <= port.data_bus;
      bus_sync <= bus_meta;
    end
  end
  // Sequencer: R09 program followed by verify
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= IDLE;
      cnt <= '0;
      wdata <= '0;
      port.addr_high <= '0;
      port.addr_low <= '0;
      port.data_host_out <= '0;
      port.data_host_oe_n <= 1'b1;
      port.chip_sel_n <= 1'b1;
      port.read_drive_n <= 1'b1;
      port.programming_level <= 1'b0;
      DONE_O <= 1'b0;
      RDATA_O <= '0;
      MISMATCH_O <= 1'b0;
    end else if (CLOCK_EN_I) begin
      DONE_O <= 1'b0;
      cnt <= cnt + 8'h01;
      case (state)
        IDLE: begin
          if (REQ_I) begin
            // R01 address on ports 2 and 1
            port.addr_high <= ADDR_I[15:8];
            port.addr_low <= ADDR_I[7:0];
            wdata <= WDATA_I;
            port.data_host_out <= WDATA_I;
            cnt <= '0;
            if (OP_I == flash_port_pkg::OP_READ) begin
              // R04 read select
              port.chip_sel_n <= 1'b0;
              port.read_drive_n <= 1'b0;
              state <= SAMPLE;
            end else begin
              // Raise the programming level while still deselected
              port.programming_level <= 1'b1;
              port.read_drive_n <= 1'b1;
              state <= SETUP;
            end
          end
        end
        // Turnaround: the device lets go of the data pins first
        SETUP: begin
          if (cnt == 8'(flash_port_pkg::SETTLE_CYCLES)) begin
            // R07 program select at 12V
            port.chip_sel_n <= 1'b0;
            port.data_host_oe_n <= 1'b0;
            cnt <= '0;
            state <= PROG;
          end
        end
        PROG: begin
          if (cnt == 8'(flash_port_pkg::PROG_CYCLES +
              flash_port_pkg::SETTLE_CYCLES)) begin
            // R08 switch to verify
            port.data_host_oe_n <= 1'b1;
            port.chip_sel_n <= 1'b1;
            port.read_drive_n <= 1'b0;
            cnt <= '0;
            state <= VERIFY;
          end
        end
        VERIFY, SAMPLE: begin
          if (cnt == 8'(flash_port_pkg::SETTLE_CYCLES + 2)) begin
            RDATA_O <= bus_sync;
            MISMATCH_O <= (state == VERIFY) && (bus_sync != wdata);
            DONE_O <= 1'b1;
            port.chip_sel_n <= 1'b1;
            port.read_drive_n <= 1'b1;
            port.programming_level <= 1'b0;
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
  // R03 static strap levels, R02 control lines low
  assign port.flash_ctrl_line = 4'h0;
  assign port.reset_pin = 1'b1;
  assign port.addr_latch_n = 1'b0;
  assign port.program_store_strobe_n = 1'b1;
  assign port.supply_high = !port.programming_level;
  assign BUSY_O = (state != IDLE);
endmodule

// ===== test/flash_port_assertions.sv
// Watches the programming pins between the host and the device ends
module flash_port_assertions (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic [3:0] flash_ctrl_line,
  input wire logic chip_sel_n,
  input wire logic read_drive_n,
  input wire logic programming_level,
  input wire logic supply_high,
  input wire logic reset_pin,
  input wire logic addr_latch_n,
  input wire logic program_store_strobe_n,
  input wire logic data_host_oe_n,
  input wire logic data_dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Decoded pin combinations
  wire base = flash_ctrl_line == 4'h0;
  wire rd_sel = base && !chip_sel_n && !read_drive_n && supply_high;
  wire pg_sel = base && !chip_sel_n && read_drive_n && programming_level;
  wire vf_sel = base && chip_sel_n && !read_drive_n && programming_level;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  property p_ctrl_idle; flash_ctrl_line == 4'h0; endproperty
  property p_strap; reset_pin && !addr_latch_n && program_store_strobe_n;
  endproperty
  property p_supply; supply_high == !programming_level; endproperty
  property p_read_drive; rd_sel [*5] |-> !data_dev_oe_n; endproperty
  property p_verify_drive; vf_sel [*5] |-> !data_dev_oe_n; endproperty
  property p_release; (!rd_sel && !vf_sel) [*5] |-> data_dev_oe_n;
  endproperty
  property p_no_fight; data_dev_oe_n || data_host_oe_n; endproperty
  property p_prog_host; pg_sel |-> !data_host_oe_n; endproperty
  property p_prog_verify; $fell(pg_sel) |-> ##[0:2] vf_sel; endproperty
  a_ctrl_idle: assert property (p_ctrl_idle)
    else $error("control lines not low");
  a_strap: assert property (p_strap)
    else $error("strap pins wrong");
  a_supply: assert property (p_supply)
    else $error("supply levels disagree");
  a_read_drive: assert property (p_read_drive)
    else $error("read not driven");
  a_verify_drive: assert property (p_verify_drive)
    else $error("verify not driven");
  a_release: assert property (p_release)
    else $error("data driven outside read or verify");
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data");
  a_prog_host: assert property (p_prog_host)
    else $error("program without host data");
  a_prog_verify: assert property (p_prog_verify)
    else $error("no verify after program");
  c_read: cover property (rd_sel [*5]);
  c_verify: cover property (vf_sel [*5]);
  c_program: cover property ($fell(pg_sel));
endmodule

// ===== test/flash_program_port_and_options_tb.sv
module flash_program_port_and_options_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    flash_port_pkg::op_e op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic mis;
  } row_s;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  flash_port_pkg::op_e op = flash_port_pkg::OP_READ;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic t_rd = 1'b0;
  logic t_ext = 1'b0;
  logic [15:0] t_addr = 16'h0000;
  logic busy, done, mis, t_ok, locked, restricted, got_mis;
  logic [7:0] rdata, t_data, got;
  int n_mismatch = 0;
  int total_checks = 0;
  // Program, verify and read rows; the last program only clears bits
  row_s rows [7] = '{
    '{flash_port_pkg::OP_PROGRAM, 16'h0000, 8'hA5, 8'hA5, 1'b0},
    '{flash_port_pkg::OP_VERIFY, 16'h0FFF, 8'h3C, 8'h3C, 1'b0},
    '{flash_port_pkg::OP_PROGRAM, 16'h0123, 8'h5A, 8'h5A, 1'b0},
    '{flash_port_pkg::OP_READ, 16'h0000, 8'h00, 8'hA5, 1'b0},
    '{flash_port_pkg::OP_READ, 16'h0FFF, 8'h00, 8'h3C, 1'b0},
    '{flash_port_pkg::OP_PROGRAM, 16'h0000, 8'h0F, 8'h05, 1'b1},
    '{flash_port_pkg::OP_READ, 16'h0000, 8'h00, 8'h05, 1'b0}};
  flash_port_if port_if();
  flash_port_device i_flash_port_device (.CLOCK_I(clock),
    .RESETN_I(resetn), .CLOCK_EN_I(1'b1), .port(port_if.device),
    .TABLE_READ_I(t_rd), .TABLE_FROM_EXTERNAL_I(t_ext),
    .TABLE_ADDR_I(t_addr), .TABLE_INTERNAL_OK_O(t_ok),
    .TABLE_DATA_O(t_data), .LOCKED_O(locked), .RESTRICTED_O(restricted));
  flash_port_host i_flash_port_host (.CLOCK_I(clock), .RESETN_I(resetn),
    .CLOCK_EN_I(1'b1), .port(port_if.host), .REQ_I(req), .OP_I(op),
    .ADDR_I(addr), .WDATA_I(wdata), .BUSY_O(busy), .DONE_O(done),
    .RDATA_O(rdata), .MISMATCH_O(mis));
  flash_port_assertions i_flash_port_assertions (.CLOCK_I(clock),
    .RESETN_I(resetn), .flash_ctrl_line(port_if.flash_ctrl_line),
    .chip_sel_n(port_if.chip_sel_n), .read_drive_n(port_if.read_drive_n),
    .programming_level(port_if.programming_level),
    .supply_high(port_if.supply_high), .reset_pin(port_if.reset_pin),
    .addr_latch_n(port_if.addr_latch_n),
    .program_store_strobe_n(port_if.program_store_strobe_n),
    .data_host_oe_n(port_if.data_host_oe_n),
    .data_dev_oe_n(port_if.data_dev_oe_n));
  // Free running clock
  initial begin
    forever #20 clock = ~clock;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // One host operation, waits for its done pulse
  task automatic run_op(input flash_port_pkg::op_e o,
    input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    while (busy !== 1'b0 || done !== 1'b0) @(negedge clock);
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    @(negedge clock);
    req = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (n >= 200) begin
      n_mismatch++;
      $display("[FAIL] %0t no done", $time);
    end
    got = rdata;
    got_mis = mis;
  endtask
  // One table read, answer checked one edge later
  task automatic tread(input logic e, input logic [15:0] a,
    input logic ok, input logic [7:0] d);
    t_rd = 1'b1;
    t_ext = e;
    t_addr = a;
    @(negedge clock);
    t_rd = 1'b0;
    chk({7'h00, t_ok}, {7'h00, ok});
    chk(t_data, d);
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    chk({6'h00, locked, restricted}, 8'h00);
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].addr, rows[i].wdata);
      chk(got, rows[i].rdata);
      if (rows[i].op != flash_port_pkg::OP_READ)
        chk({7'h00, got_mis}, {7'h00, rows[i].mis});
    end
    tread(1'b1, 16'h0123, 1'b1, 8'h5A);
    run_op(flash_port_pkg::OP_PROGRAM, flash_port_pkg::OPTION_ADDR,
      8'hFD);
    chk({7'h00, restricted}, 8'h01);
    tread(1'b1, 16'h0123, 1'b0, 8'h00);
    tread(1'b0, 16'h0123, 1'b1, 8'h5A);
    run_op(flash_port_pkg::OP_PROGRAM, flash_port_pkg::OPTION_ADDR,
      8'hFE);
    chk({7'h00, locked}, 8'h01);
    run_op(flash_port_pkg::OP_READ, 16'h0000, 8'h00);
    chk(got, flash_port_pkg::LOCKED_READ);
    run_op(flash_port_pkg::OP_PROGRAM, 16'h0123, 8'h00);
    tread(1'b0, 16'h0123, 1'b1, 8'h5A);
    run_op(flash_port_pkg::OP_READ, flash_port_pkg::OPTION_ADDR,
      8'h00);
    chk({6'h00, got[1:0]}, 8'h00);
    // Mid-run reset restores the options and idles the host
    resetn = 1'b0;
    repeat (8) @(negedge clock);
    resetn = 1'b1;
    chk({5'h00, busy, locked, restricted}, 8'h00);
    run_op(flash_port_pkg::OP_PROGRAM, 16'h0456, 8'h96);
    chk(got, 8'h96);
    chk({7'h00, got_mis}, 8'h00);
    wrap_up;
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
